// ==== rtl/aqm_pkg.sv ====
package aqm_pkg;

  // ------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int AQM_AW = 24;
  localparam logic [23:0] AQM_IDX_Q1 = 24'hca000c;
  localparam logic [23:0] AQM_IDX_Q2 = 24'hca000e;
  localparam logic [23:0] AQM_IDX_CS = 24'hca0020;

  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [15:0] AQM_Q1_RST = 16'h0000;
  localparam logic [15:0] AQM_Q2_RST = 16'h007f;
  localparam int AQM_B_CIE = 15;
  localparam int AQM_B_PIE = 14;
  localparam int AQM_B_SSE = 13;
  localparam int AQM_B_MQ_HI = 12;
  localparam int AQM_B_MQ_LO = 8;
  localparam int AQM_B_RES = 7;
  localparam int AQM_B_BQ_HI = 6;
  localparam int AQM_CS_TEST = 0;
  localparam int AQM_CS_Q1RUN = 1;
  localparam int AQM_CS_Q2RUN = 2;
  localparam int AQM_CS_Q1RSV = 3;
  localparam int AQM_CS_Q2RSV = 4;

  // ------------------------------------------------------------
  // Operating mode codes
  // ------------------------------------------------------------
  localparam logic [4:0] AQM_MQ_OFF = 5'h00;
  localparam logic [4:0] AQM_MQ_SW_S = 5'h01;
  localparam logic [4:0] AQM_MQ_RISE_S = 5'h02;
  localparam logic [4:0] AQM_MQ_FALL_S = 5'h03;
  localparam logic [4:0] AQM_MQ_TMR_S_LO = 5'h04;
  localparam logic [4:0] AQM_MQ_TMR_S_HI = 5'h0e;
  localparam logic [4:0] AQM_MQ_GATE_S = 5'h0f;
  localparam logic [4:0] AQM_MQ_RSVD = 5'h10;
  localparam logic [4:0] AQM_MQ_SW_C = 5'h11;
  localparam logic [4:0] AQM_MQ_RISE_C = 5'h12;
  localparam logic [4:0] AQM_MQ_FALL_C = 5'h13;
  localparam logic [4:0] AQM_MQ_TMR_C_LO = 5'h14;
  localparam logic [4:0] AQM_MQ_TMR_C_HI = 5'h1e;
  localparam logic [4:0] AQM_MQ_GATE_C = 5'h1f;
  localparam int AQM_MQ_CONT_BIT = 4;

  // ------------------------------------------------------------
  // Timer and queue boundary constants
  // ------------------------------------------------------------
  localparam int AQM_TMR_W = 17;
  localparam logic [4:0] AQM_TMR_EXP_OFS = 5'h03;
  localparam logic [6:0] AQM_BQ_LIMIT = 7'h40;
  localparam logic [5:0] AQM_Q1_LAST_MAX = 6'h3f;

  typedef enum logic [6:0] {
    AQM_MD_OFF   = 7'b0000001,
    AQM_MD_SW    = 7'b0000010,
    AQM_MD_RISE  = 7'b0000100,
    AQM_MD_FALL  = 7'b0001000,
    AQM_MD_TIMER = 7'b0010000,
    AQM_MD_GATE  = 7'b0100000,
    AQM_MD_RSVD  = 7'b1000000
  } aqm_mode_t;

  typedef enum logic [1:0] {
    AQM_QS_IDLE = 2'b01,
    AQM_QS_RUN  = 2'b10
  } aqm_qstate_t;

endpackage

// ==== rtl/aqm_evt_if.sv ====
`timescale 1ns/1ps
interface aqm_evt_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ==== rtl/aqm_trig_sync.sv ====
`timescale 1ns/1ps
module aqm_trig_sync (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Asynchronous trigger or gate pin
  input wire logic i_pin,
  // Qualified events
  aqm_evt_if.src evt
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } aqm_sync_state_t;

  aqm_sync_state_t st_ff;
  aqm_sync_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = i_pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.s2;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // One pulse per edge of the synchronised level
  assign evt.level = st_ff.s2;
  assign evt.rise = st_ff.s2 & ~st_ff.prev;
  assign evt.fall = ~st_ff.s2 & st_ff.prev;
endmodule // aqm_trig_sync

// ==== rtl/aqm_interval_timer.sv ====
`timescale 1ns/1ps
module aqm_interval_timer #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [4:0] i_exp,
  // Expiry pulse
  output logic o_expire
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic expire;
  } aqm_tmr_state_t;

  aqm_tmr_state_t st_ff;
  aqm_tmr_state_t nxt_st;
  logic [W:0] one_sh;
  logic [W-1:0] last_cnt;

  // Terminal count is 2^exp converter clock periods minus one
  assign one_sh = {{W{1'b0}}, 1'b1} << i_exp;
  assign last_cnt = W'(one_sh - 1'b1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.expire = 1'b0;
    if (!i_run) begin
      nxt_st.cnt = '0;
    end else if (i_tick) begin
      if (st_ff.cnt == last_cnt) begin
        nxt_st.cnt = '0;
        nxt_st.expire = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_expire = st_ff.expire;
endmodule // aqm_interval_timer

// ==== rtl/aqm_queue_mode_ctrl.sv ====
// Function
// - Queue 1 pause interrupt on paused word done
// - Queue 1 arm accepted with single-scan mode write
// - Arm bits read zero unless test mode
// - Queue 1 arm clears when single scan ends
// - Queue 1 single-scan triggers need arm bit
// - Queue 1 codes zero to three decode
// - Queue 1 interval timer codes, powers seven-seventeen
// - Queue 1 gated single; code sixteen reserved
// - Queue 1 software and edge continuous codes
// - Queue 1 periodic timer continuous codes
// - Queue 1 top code is gated continuous
// - Stop mode forces queue 2 register
// - Queue 2 register readable; stop blocks writes
// - Queue 2 completion interrupt on last word
// - Queue 2 pause interrupt on paused word
// - Queue 2 arm accepted, cleared at scan end
// - Queue 2 single-scan triggers need arm bit
// - Queue 2 codes zero to three decode
// - Queue 2 interval timer codes from four
// - Queue 1 completion interrupt on last word
// - Begin pointer splits table between queues
// - Resume bit picks queue 2 restart point
`timescale 1ns/1ps
module aqm_queue_mode_ctrl #(
  parameter int TMR_W = aqm_pkg::AQM_TMR_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [aqm_pkg::AQM_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // System state and converter clock
  input wire logic i_stop_mode,
  input wire logic i_converter_clock_tick,
  // External trigger and gate pins
  input wire logic i_q1_trig_pin,
  input wire logic i_q2_trig_pin,
  // Conversion completion from the converter
  input wire logic i_cv_done,
  input wire logic i_cv_queue2,
  input wire logic i_cv_pause,
  input wire logic i_cv_last,
  // Queue starts and settings
  output logic o_q1_start,
  output logic o_q2_start,
  output logic o_q1_continuous,
  output logic o_q2_continuous,
  output logic o_q1_gate_open,
  output logic o_q2_gate_open,
  output logic o_q2_resume,
  output logic [6:0] o_q2_begin_pointer,
  output logic [5:0] o_q1_last_entry,
  output logic o_q1_empty,
  output logic o_q2_empty,
  // Interrupt requests
  output logic o_q1_complete_irq,
  output logic o_q1_pause_irq,
  output logic o_q2_complete_irq,
  output logic o_q2_pause_irq
);
  import aqm_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic q1_complete_irq_en;
    logic q1_pause_irq_en;
    logic q1_single_scan_arm;
    logic [4:0] q1_operating_mode;
    logic q2_complete_irq_en;
    logic q2_pause_irq_en;
    logic q2_single_scan_arm;
    logic [4:0] q2_operating_mode;
    logic q2_resume_sel;
    logic [6:0] q2_begin_pointer;
    logic test_mode;
    aqm_qstate_t q1_st;
    aqm_qstate_t q2_st;
    logic q2_resume_lat;
    logic q1_start;
    logic q2_start;
    logic q1_cpl_irq;
    logic q1_pse_irq;
    logic q2_cpl_irq;
    logic q2_pse_irq;
  } aqm_top_state_t;

  aqm_top_state_t st_ff;
  aqm_top_state_t nxt_st;

  // ------------------------------------------------------------
  // Trigger synchronisers and interval timers
  // ------------------------------------------------------------
  aqm_evt_if q1_evt();
  aqm_evt_if q2_evt();

  aqm_trig_sync u_q1_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_q1_trig_pin),
    .evt(q1_evt)
  );

  aqm_trig_sync u_q2_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_q2_trig_pin),
    .evt(q2_evt)
  );

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  function automatic aqm_mode_t decode_mode(input logic [4:0] code, input logic is_q2);
    aqm_mode_t m;
    m = AQM_MD_RSVD;
    case (code)
      AQM_MQ_OFF: m = AQM_MD_OFF;
      AQM_MQ_SW_S, AQM_MQ_SW_C: m = AQM_MD_SW;
      AQM_MQ_RISE_S, AQM_MQ_RISE_C: m = AQM_MD_RISE;
      AQM_MQ_FALL_S, AQM_MQ_FALL_C: m = AQM_MD_FALL;
      AQM_MQ_GATE_S, AQM_MQ_GATE_C: m = is_q2 ? AQM_MD_RSVD : AQM_MD_GATE;
      AQM_MQ_RSVD: m = AQM_MD_RSVD;
      default: begin
        if ((code >= AQM_MQ_TMR_S_LO && code <= AQM_MQ_TMR_S_HI) ||
            (code >= AQM_MQ_TMR_C_LO && code <= AQM_MQ_TMR_C_HI)) begin
          m = AQM_MD_TIMER;
        end
      end
    endcase
    return m;
  endfunction

  aqm_mode_t q1_cls;
  aqm_mode_t q2_cls;
  logic q1_cont;
  logic q2_cont;
  logic [4:0] q1_exp;
  logic [4:0] q2_exp;
  logic q1_tmr_run;
  logic q2_tmr_run;
  logic q1_tmr_exp;
  logic q2_tmr_exp;

  assign q1_cls = decode_mode(st_ff.q1_operating_mode, 1'b0);
  assign q2_cls = decode_mode(st_ff.q2_operating_mode, 1'b1);
  assign q1_cont = st_ff.q1_operating_mode[AQM_MQ_CONT_BIT];
  assign q2_cont = st_ff.q2_operating_mode[AQM_MQ_CONT_BIT];
  // Low nibble 4..14 maps to exponent 7..17 for both scan forms
  assign q1_exp = {1'b0, st_ff.q1_operating_mode[3:0]} + AQM_TMR_EXP_OFS;
  assign q2_exp = {1'b0, st_ff.q2_operating_mode[3:0]} + AQM_TMR_EXP_OFS;
  assign q1_tmr_run = (q1_cls == AQM_MD_TIMER) && (q1_cont || st_ff.q1_single_scan_arm);
  assign q2_tmr_run = (q2_cls == AQM_MD_TIMER) && (q2_cont || st_ff.q2_single_scan_arm);

  aqm_interval_timer #(.W(TMR_W)) u_q1_tmr (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_run(q1_tmr_run),
    .i_tick(i_converter_clock_tick),
    .i_exp(q1_exp),
    .o_expire(q1_tmr_exp)
  );

  aqm_interval_timer #(.W(TMR_W)) u_q2_tmr (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_run(q2_tmr_run),
    .i_tick(i_converter_clock_tick),
    .i_exp(q2_exp),
    .o_expire(q2_tmr_exp)
  );

  // ------------------------------------------------------------
  // Trigger qualification
  // ------------------------------------------------------------
  function automatic logic fire(input aqm_mode_t cls, input logic cont, input logic arm,
                                input logic rise, input logic fall, input logic tmr);
    logic ev;
    ev = 1'b0;
    case (cls)
      AQM_MD_SW: ev = 1'b1;
      AQM_MD_RISE: ev = rise;
      AQM_MD_FALL: ev = fall;
      AQM_MD_TIMER: ev = tmr;
      AQM_MD_GATE: ev = rise;
      default: ev = 1'b0;
    endcase
    return ev && (cont || arm);
  endfunction

  logic q1_fire;
  logic q2_fire;
  logic q1_done;
  logic q2_done;

  assign q1_fire = (st_ff.q1_st == AQM_QS_IDLE) &&
                   fire(q1_cls, q1_cont, st_ff.q1_single_scan_arm,
                        q1_evt.rise, q1_evt.fall, q1_tmr_exp);
  assign q2_fire = (st_ff.q2_st == AQM_QS_IDLE) &&
                   fire(q2_cls, q2_cont, st_ff.q2_single_scan_arm,
                        q2_evt.rise, q2_evt.fall, q2_tmr_exp);
  assign q1_done = i_cv_done && !i_cv_queue2 && i_cv_last;
  assign q2_done = i_cv_done && i_cv_queue2 && i_cv_last;

  // ------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------
  logic req;
  logic take;
  logic sel_q1;
  logic sel_q2;
  logic sel_cs;
  logic [15:0] q1_word;
  logic [15:0] q2_word;
  logic [15:0] q1_view;
  logic [15:0] q2_view;
  logic [15:0] cs_word;
  logic [31:0] rd_word;
  logic [15:0] wr_q1;
  logic [15:0] wr_q2;
  logic [15:0] wr_cs;

  assign req = i_avs_read || i_avs_write;
  assign take = req && st_ff.ack;
  assign sel_q1 = (i_avs_address == AQM_IDX_Q1);
  assign sel_q2 = (i_avs_address == AQM_IDX_Q2);
  assign sel_cs = (i_avs_address == AQM_IDX_CS);
  assign o_avs_waitrequest = req && !st_ff.ack;

  assign q1_word = {st_ff.q1_complete_irq_en, st_ff.q1_pause_irq_en, st_ff.q1_single_scan_arm,
                    st_ff.q1_operating_mode, 8'h00};
  assign q2_word = {st_ff.q2_complete_irq_en, st_ff.q2_pause_irq_en, st_ff.q2_single_scan_arm,
                    st_ff.q2_operating_mode, st_ff.q2_resume_sel, st_ff.q2_begin_pointer};
  assign q1_view = {q1_word[15:14], q1_word[AQM_B_SSE] & st_ff.test_mode, q1_word[12:0]};
  assign q2_view = {q2_word[15:14], q2_word[AQM_B_SSE] & st_ff.test_mode, q2_word[12:0]};
  assign cs_word = {11'h000, q2_cls == AQM_MD_RSVD, q1_cls == AQM_MD_RSVD,
                    st_ff.q2_st == AQM_QS_RUN, st_ff.q1_st == AQM_QS_RUN, st_ff.test_mode};

  always_comb begin
    rd_word = 32'h00000000;
    if (sel_q1) begin
      rd_word = {16'h0000, q1_view};
    end else if (sel_q2) begin
      rd_word = {16'h0000, q2_view};
    end else if (sel_cs) begin
      rd_word = {16'h0000, cs_word};
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  assign wr_q1 = merge16(q1_word, i_avs_writedata, i_avs_byteenable);
  assign wr_q2 = merge16(q2_word, i_avs_writedata, i_avs_byteenable);
  assign wr_cs = merge16(cs_word, i_avs_writedata, i_avs_byteenable);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.q1_start = 1'b0;
    nxt_st.q2_start = 1'b0;
    nxt_st.q1_cpl_irq = 1'b0;
    nxt_st.q1_pse_irq = 1'b0;
    nxt_st.q2_cpl_irq = 1'b0;
    nxt_st.q2_pse_irq = 1'b0;
    nxt_st.ack = req && !st_ff.ack;
    if (req && !st_ff.ack) begin
      nxt_st.rdata = rd_word;
    end
    // Conversion events
    if (i_cv_done && !i_cv_queue2 && i_cv_pause && st_ff.q1_pause_irq_en) begin
      nxt_st.q1_pse_irq = 1'b1;
    end
    if (q1_done && st_ff.q1_complete_irq_en) begin
      nxt_st.q1_cpl_irq = 1'b1;
    end
    if (i_cv_done && i_cv_queue2 && i_cv_pause && st_ff.q2_pause_irq_en) begin
      nxt_st.q2_pse_irq = 1'b1;
    end
    if (q2_done && st_ff.q2_complete_irq_en) begin
      nxt_st.q2_cpl_irq = 1'b1;
    end
    // Queue sequencing
    case (st_ff.q1_st)
      AQM_QS_IDLE: begin
        if (q1_fire) begin
          nxt_st.q1_start = 1'b1;
          nxt_st.q1_st = AQM_QS_RUN;
        end
      end
      AQM_QS_RUN: begin
        if (q1_done) begin
          nxt_st.q1_st = AQM_QS_IDLE;
          if (!q1_cont) begin
            nxt_st.q1_single_scan_arm = 1'b0;
          end
        end
      end
      default: nxt_st.q1_st = AQM_QS_IDLE;
    endcase
    case (st_ff.q2_st)
      AQM_QS_IDLE: begin
        if (q2_fire) begin
          nxt_st.q2_start = 1'b1;
          nxt_st.q2_st = AQM_QS_RUN;
          nxt_st.q2_resume_lat = st_ff.q2_resume_sel;
        end
      end
      AQM_QS_RUN: begin
        if (q2_done) begin
          nxt_st.q2_st = AQM_QS_IDLE;
          if (!q2_cont) begin
            nxt_st.q2_single_scan_arm = 1'b0;
          end
        end
      end
      default: nxt_st.q2_st = AQM_QS_IDLE;
    endcase
    // Register writes; a written arm of 1 wins over the hardware clear
    if (take && i_avs_write && !i_stop_mode) begin
      if (sel_q1) begin
        nxt_st.q1_complete_irq_en = wr_q1[AQM_B_CIE];
        nxt_st.q1_pause_irq_en = wr_q1[AQM_B_PIE];
        nxt_st.q1_single_scan_arm = wr_q1[AQM_B_SSE];
        nxt_st.q1_operating_mode = wr_q1[AQM_B_MQ_HI:AQM_B_MQ_LO];
        if (wr_q1[AQM_B_MQ_HI:AQM_B_MQ_LO] != st_ff.q1_operating_mode) begin
          nxt_st.q1_st = AQM_QS_IDLE;
        end
      end
      if (sel_q2) begin
        nxt_st.q2_complete_irq_en = wr_q2[AQM_B_CIE];
        nxt_st.q2_pause_irq_en = wr_q2[AQM_B_PIE];
        nxt_st.q2_single_scan_arm = wr_q2[AQM_B_SSE];
        nxt_st.q2_operating_mode = wr_q2[AQM_B_MQ_HI:AQM_B_MQ_LO];
        nxt_st.q2_resume_sel = wr_q2[AQM_B_RES];
        nxt_st.q2_begin_pointer = wr_q2[AQM_B_BQ_HI:0];
        if (wr_q2[AQM_B_MQ_HI:AQM_B_MQ_LO] != st_ff.q2_operating_mode) begin
          nxt_st.q2_st = AQM_QS_IDLE;
          nxt_st.q2_resume_lat = wr_q2[AQM_B_RES];
        end
      end
      if (sel_cs) begin
        nxt_st.test_mode = wr_cs[AQM_CS_TEST];
      end
    end
    // Stop mode returns both queue registers to their reset images
    if (i_stop_mode) begin
      {nxt_st.q1_complete_irq_en, nxt_st.q1_pause_irq_en, nxt_st.q1_single_scan_arm,
       nxt_st.q1_operating_mode} = AQM_Q1_RST[AQM_B_CIE:AQM_B_MQ_LO];
      {nxt_st.q2_complete_irq_en, nxt_st.q2_pause_irq_en, nxt_st.q2_single_scan_arm,
       nxt_st.q2_operating_mode, nxt_st.q2_resume_sel,
       nxt_st.q2_begin_pointer} = AQM_Q2_RST;
      nxt_st.q1_st = AQM_QS_IDLE;
      nxt_st.q2_st = AQM_QS_IDLE;
      nxt_st.q1_start = 1'b0;
      nxt_st.q2_start = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
      {st_ff.q1_complete_irq_en, st_ff.q1_pause_irq_en, st_ff.q1_single_scan_arm,
       st_ff.q1_operating_mode} <= AQM_Q1_RST[AQM_B_CIE:AQM_B_MQ_LO];
      {st_ff.q2_complete_irq_en, st_ff.q2_pause_irq_en, st_ff.q2_single_scan_arm,
       st_ff.q2_operating_mode, st_ff.q2_resume_sel, st_ff.q2_begin_pointer} <= AQM_Q2_RST;
      st_ff.q1_st <= AQM_QS_IDLE;
      st_ff.q2_st <= AQM_QS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_avs_readdata = st_ff.rdata;
  assign o_q1_start = st_ff.q1_start;
  assign o_q2_start = st_ff.q2_start;
  assign o_q1_continuous = q1_cont;
  assign o_q2_continuous = q2_cont;
  assign o_q1_gate_open = (q1_cls == AQM_MD_GATE) && q1_evt.level &&
                          (q1_cont || st_ff.q1_single_scan_arm);
  assign o_q2_gate_open = (q2_cls == AQM_MD_GATE) && q2_evt.level &&
                          (q2_cont || st_ff.q2_single_scan_arm);
  assign o_q2_resume = st_ff.q2_resume_lat;
  assign o_q2_begin_pointer = st_ff.q2_begin_pointer;
  assign o_q2_empty = (st_ff.q2_begin_pointer >= AQM_BQ_LIMIT);
  assign o_q1_empty = (st_ff.q2_begin_pointer == 7'h00);
  assign o_q1_last_entry = o_q2_empty ? AQM_Q1_LAST_MAX :
                           6'(st_ff.q2_begin_pointer - 7'h01);
  assign o_q1_complete_irq = st_ff.q1_cpl_irq;
  assign o_q1_pause_irq = st_ff.q1_pse_irq;
  assign o_q2_complete_irq = st_ff.q2_cpl_irq;
  assign o_q2_pause_irq = st_ff.q2_pse_irq;
endmodule // aqm_queue_mode_ctrl

// ==== tb/aqm_queue_mode_ctrl_sva.sv ====
`timescale 1ns/1ps
module aqm_queue_mode_ctrl_sva (
  input wire logic i_clk_sys, i_sys_rst, i_avs_read, i_avs_write, o_avs_waitrequest,
  input wire logic i_stop_mode, i_cv_done, i_cv_queue2, i_cv_pause, i_cv_last,
  input wire logic o_q1_start, o_q2_start, o_q1_empty, o_q2_empty,
  input wire logic [6:0] o_q2_begin_pointer,
  input wire logic o_q1_complete_irq, o_q1_pause_irq, o_q2_complete_irq, o_q2_pause_irq
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus wait not one cycle");
  q1_pause_a: assert property (o_q1_pause_irq
    |-> $past(i_cv_done && !i_cv_queue2 && i_cv_pause)) else $error("q1 pause irq");
  q1_done_a: assert property (o_q1_complete_irq
    |-> $past(i_cv_done && !i_cv_queue2 && i_cv_last)) else $error("q1 done irq");
  q2_done_a: assert property (o_q2_complete_irq
    |-> $past(i_cv_done && i_cv_queue2 && i_cv_last)) else $error("q2 done irq");
  q2_pause_a: assert property (o_q2_pause_irq
    |-> $past(i_cv_done && i_cv_queue2 && i_cv_pause)) else $error("q2 pause irq");
  stop_force_a: assert property (i_stop_mode
    |=> o_q2_begin_pointer == 7'h7f && o_q2_empty) else $error("stop not forced");
  table_split_a: assert property (o_q2_empty == (o_q2_begin_pointer >= 7'h40)
    && o_q1_empty == (o_q2_begin_pointer == 7'h00)) else $error("split wrong");
  q1_pulse_a: assert property (o_q1_start |=> !o_q1_start) else $error("q1 start");
  q2_pulse_a: assert property (o_q2_start |=> !o_q2_start) else $error("q2 start");
  cover property (o_q1_start);
  cover property (o_q2_pause_irq);
  cover property (i_stop_mode ##1 !i_stop_mode);
endmodule // aqm_queue_mode_ctrl_sva
bind aqm_queue_mode_ctrl aqm_queue_mode_ctrl_sva chk_u (.*);

// ==== tb/aqm_queue_mode_ctrl_tb.sv ====
`timescale 1ns/1ps
module aqm_queue_mode_ctrl_tb;
  import aqm_pkg::*;
  logic i_clk_sys = 0, i_sys_rst = 1, i_avs_read = 0, i_avs_write = 0, i_stop_mode = 0;
  logic i_converter_clock_tick = 0, i_q1_trig_pin = 0, i_q2_trig_pin = 0, i_cv_done = 0;
  logic i_cv_queue2 = 0, i_cv_pause = 0, i_cv_last = 0, o_avs_waitrequest;
  logic [23:0] i_avs_address = '0;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata;
  logic [3:0] i_avs_byteenable = 4'h3;
  logic o_q1_start, o_q2_start, o_q1_continuous, o_q2_continuous, o_q1_gate_open;
  logic o_q2_gate_open, o_q2_resume, o_q1_empty, o_q2_empty, o_q1_complete_irq;
  logic o_q1_pause_irq, o_q2_complete_irq, o_q2_pause_irq;
  logic [6:0] o_q2_begin_pointer;
  logic [5:0] o_q1_last_entry;
  int mismatches = 0, compares = 0, cnt [6] = '{default: 0}, s [6];
  wire [5:0] pv = {o_q2_pause_irq, o_q2_complete_irq, o_q1_pause_irq, o_q1_complete_irq,
    o_q2_start, o_q1_start};
  aqm_queue_mode_ctrl dut_u (.*);
  // ------------------------------------------------------------
  // Clock, pulse counters and bus tasks
  // ------------------------------------------------------------
  always #50 i_clk_sys = ~i_clk_sys;
  // Pulses are counted mid-cycle so that tallies never race the checks at the rising edge
  always @(negedge i_clk_sys) for (int k = 0; k < 6; k++) cnt[k] += pv[k];
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic bus(input logic w, input logic [23:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= {16'h0000, d};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic wr16(input logic [23:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [23:0] a, input logic [15:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(nm, q, {16'h0000, e});
  endtask
  task automatic cv(input logic q2, input logic ps, input logic ls);
    @(posedge i_clk_sys);
    i_cv_done <= 1'b1;
    i_cv_queue2 <= q2;
    i_cv_pause <= ps;
    i_cv_last <= ls;
    @(posedge i_clk_sys);
    i_cv_done <= 1'b0;
  endtask
  task automatic pin2(input logic v);
    @(posedge i_clk_sys);
    i_q2_trig_pin <= v;
    cyc(8);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [15:0] d;
    int n;
    void'($urandom(32'h7b9b));
    cyc(8);
    i_sys_rst <= 1'b0;
    rdchk(AQM_IDX_Q1, 16'h0000, "q1 reset");
    rdchk(AQM_IDX_Q2, 16'h007f, "q2 reset");
    rdchk(24'h000123, 16'h0000, "unmapped");
    $display("done reset");
    wr16(AQM_IDX_CS, 16'h0001);
    s = cnt;
    wr16(AQM_IDX_Q1, 16'he100);
    cyc(3);
    chk("q1 sw start", cnt[0] - s[0], 1);
    rdchk(AQM_IDX_Q1, 16'he100, "q1 armed");
    cv(0, 1, 1);
    cyc(2);
    chk("q1 pause irq", cnt[3] - s[3], 1);
    chk("q1 done irq", cnt[2] - s[2], 1);
    rdchk(AQM_IDX_Q1, 16'hc100, "q1 arm cleared");
    wr16(AQM_IDX_CS, 16'h0000);
    $display("done single scan");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'h2040 : (i == 1) ? 16'h003f : 16'($urandom) & 16'h20ff;
      wr16(AQM_IDX_Q2, d);
      rdchk(AQM_IDX_Q2, d & 16'h00ff, "q2 readback");
      chk("begin ptr", o_q2_begin_pointer, d[6:0]);
      chk("q1 last", o_q1_last_entry, d[6] ? 6'h3f : 6'(d[5:0] - 6'h01));
      chk("q2 empty", o_q2_empty, d[6]);
    end
    $display("done pointer");
    s = cnt;
    wr16(AQM_IDX_Q2, 16'h0220);
    pin2(1'b1);
    chk("q2 unarmed", cnt[1] - s[1], 0);
    pin2(1'b0);
    wr16(AQM_IDX_Q2, 16'he220);
    pin2(1'b1);
    chk("q2 edge start", cnt[1] - s[1], 1);
    cv(1, 1, 0);
    cv(1, 0, 1);
    cyc(2);
    chk("q2 pause irq", cnt[5] - s[5], 1);
    chk("q2 done irq", cnt[4] - s[4], 1);
    pin2(1'b0);
    pin2(1'b1);
    chk("q2 arm cleared", cnt[1] - s[1], 1);
    wr16(AQM_IDX_Q2, 16'he320);
    pin2(1'b0);
    chk("q2 fall start", cnt[1] - s[1], 2);
    $display("done edge");
    i_converter_clock_tick <= 1'b1;
    s = cnt;
    wr16(AQM_IDX_Q1, 16'h2400);
    n = 0;
    while (cnt[0] == s[0] && n < 400) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk("interval", n >= 127 && n <= 134, 1);
    if (n >= 400) print_verdict();
    i_converter_clock_tick <= 1'b0;
    cv(0, 0, 1);
    $display("done timer");
    i_stop_mode <= 1'b1;
    cyc(2);
    wr16(AQM_IDX_Q2, 16'h1234);
    rdchk(AQM_IDX_Q2, 16'h007f, "stop q2");
    i_stop_mode <= 1'b0;
    $display("done stop");
    for (int m = 0; m < 32; m++) begin
      wr16(AQM_IDX_Q1, 16'(m) << 8);
      wr16(AQM_IDX_Q2, (16'(m) << 8) | 16'h0020 | (16'(m[0]) << 7));
      bus(1'b0, AQM_IDX_CS, 16'h0000, q);
      chk("q1 reserved", q[3], m == 16);
      chk("q2 reserved", q[4], m inside {15, 16, 31});
      chk("q1 cont", o_q1_continuous, m[4]);
      chk("q2 cont", o_q2_continuous, m[4]);
      chk("q2 resume", o_q2_resume, m[0]);
    end
    $display("done modes");
    // Queue 1 is now gated continuous, queue 2 sits on a reserved code
    s = cnt;
    @(posedge i_clk_sys);
    i_q1_trig_pin <= 1'b1;
    i_q2_trig_pin <= 1'b1;
    cyc(8);
    chk("q1 gate open", o_q1_gate_open, 1);
    chk("q1 gate start", cnt[0] - s[0], 1);
    chk("q2 gate shut", o_q2_gate_open, 0);
    chk("q2 rsvd idle", cnt[1] - s[1], 0);
    $display("done gate");
    print_verdict();
  end
endmodule // aqm_queue_mode_ctrl_tb
